// ==== bench/pmcg_cpu_model.sv ====
// CPU core and interrupt controller model facing the power-mode controller
`timescale 1ns/1ps
`default_nettype none
module pmcg_cpu_model (
    // Clock and reset
    input wire logic clock,
    input wire logic arst_n,
    // Commands from the bench
    input wire logic exec_req,
    input wire logic exec_op,
    input wire logic irq_req,
    // Controller side
    input wire logic cpu_clock_enable,
    input wire logic cpu_run,
    output logic power_save_instruction,
    output logic power_save_operand,
    output logic irq_pending,
    output logic [15:0] cpu_ticks
);
    logic pend;
    // Instruction issues only on a live CPU clock; operand is junk outside it
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            pend <= 1'h0;
            power_save_instruction <= 1'h0;
            power_save_operand <= 1'h0;
            irq_pending <= 1'h0;
            cpu_ticks <= 16'h0;
        end else begin
            irq_pending <= irq_req;
            cpu_ticks <= cpu_ticks + 16'(cpu_clock_enable);
            if ((pend || exec_req) && cpu_run && cpu_clock_enable) begin
                power_save_instruction <= 1'h1;
                power_save_operand <= exec_op;
                pend <= 1'h0;
            end else begin
                power_save_instruction <= 1'h0;
                power_save_operand <= ~power_save_operand;
                pend <= pend || exec_req;
            end
        end
    end
endmodule : pmcg_cpu_model
`default_nettype wire

// ==== bench/power_mode_clock_gating_bench.sv ====
// Self-checking bench for the power-mode and clock-gating controller
`timescale 1ns/1ps
`default_nettype none
module power_mode_clock_gating_bench;
    import pmcg_pkg::*;
    localparam logic [15:0] PRESENT = 16'h7fff;
    localparam logic [31:0] DZ_EN = 32'h1 << CPU_SLOWDOWN_ENABLE_BIT;
    localparam logic [31:0] DZ_ROI = 32'h1 << ROI_BIT;
    logic clock, arst_n, avs_read, avs_write, avs_waitrequest;
    logic [3:0] avs_address;
    logic [31:0] avs_writedata, avs_readdata, rd;
    logic power_save_instruction, power_save_operand, irq_pending, cpu_clock_enable, cpu_run;
    logic watchdog_enabled, clock_fail_monitor_enabled, watchdog_timeout, watchdog_clear;
    logic low_power_rc_clock_enable, clock_fail_monitor_active, system_clock_source_on;
    logic core_regulator_standby, flash_regulator_standby, exec_req, exec_op, irq_req;
    logic [2:0] clock_source_select, restart_clock_source;
    logic [15:0] stop_in_idle, external_clocked, module_clock_enable, module_regs_enable, cpu_ticks;
    int n_errors, checked, n;

    pmcg_top #(.NUM_MODULES(16), .MODULE_PRESENT(PRESENT)) dut_u (.clock, .arst_n, .avs_address, .avs_read,
        .avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest, .power_save_instruction,
        .power_save_operand, .irq_pending, .cpu_clock_enable, .cpu_run, .watchdog_enabled,
        .clock_fail_monitor_enabled, .watchdog_timeout, .watchdog_clear, .low_power_rc_clock_enable,
        .clock_fail_monitor_active, .clock_source_select, .system_clock_source_on, .restart_clock_source,
        .core_regulator_standby, .flash_regulator_standby, .stop_in_idle, .external_clocked,
        .module_clock_enable, .module_regs_enable);
    pmcg_cpu_model cpu_u (.clock, .arst_n, .exec_req, .exec_op, .irq_req, .cpu_clock_enable, .cpu_run,
        .power_save_instruction, .power_save_operand, .irq_pending, .cpu_ticks);

    initial begin
        clock = 1'h0;
        forever #50 clock = ~clock;
    end

    task automatic test_done;
        if (n_errors == 0 && checked > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : test_done

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    // One Avalon-MM cycle; request held until waitrequest is sampled low
    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
        int k;
        @(posedge clock);
        avs_address <= a;
        avs_writedata <= d;
        avs_read <= !wr;
        avs_write <= wr;
        k = 0;
        do begin
            @(posedge clock);
            k++;
        end while (avs_waitrequest !== 1'h0 && k < 20);
        rd = avs_readdata;
        avs_read <= 1'h0;
        avs_write <= 1'h0;
        chk("bus_answer", 32'(k < 20), 32'h1);
    endtask : bus

    task automatic rchk(input string nm, input logic [3:0] a, input logic [31:0] m, input logic [31:0] e);
        bus(1'h0, a, 32'h0);
        chk(nm, rd & m, e);
    endtask : rchk

    function automatic logic [31:0] rat(input int r);
        return 32'(r) << DOZE_LSB;
    endfunction : rat

    task automatic until_run(input logic v);
        n = 0;
        while (cpu_run !== v && n < 30) begin
            @(posedge clock);
            n++;
        end
    endtask : until_run

    task automatic pwr(input logic op);
        @(posedge clock);
        exec_req <= 1'h1;
        exec_op <= op;
        @(posedge clock);
        exec_req <= 1'h0;
        until_run(1'h0);
        chk("wdt_clear", 32'(watchdog_clear), 32'h1);
    endtask : pwr

    task automatic irq(input int len);
        @(posedge clock);
        irq_req <= 1'h1;
        repeat (len) @(posedge clock);
        irq_req <= 1'h0;
    endtask : irq

    task automatic ticks(input int w, input int e);
        logic [15:0] t;
        repeat (4) @(posedge clock);
        t = cpu_ticks;
        repeat (w) @(posedge clock);
        chk("cpu_ticks", 32'(cpu_ticks - t), 32'(e));
        chk("periph_clk", 32'(module_clock_enable), 32'(PRESENT));
    endtask : ticks

    task automatic t_reset;
        rchk("clock_divisor_register", ADDR_CLOCK_DIVISOR_REGISTER, 32'hffff, 32'h0);
        rchk("reset_control_register", ADDR_RESET_CONTROL_REGISTER, 32'hffff, 32'h0);
        rchk("pmd", ADDR_PMD, 32'hffff, 32'h0);
        rchk("status", ADDR_STATUS, 32'hf, 32'h1);
        bus(1'h1, 4'h2, 32'hffff_ffff);
        rchk("unmapped", 4'h2, 32'hffff_ffff, UNMAPPED_READ);
        chk("mod_clk", 32'(module_clock_enable), 32'(PRESENT));
        chk("mod_regs", 32'(module_regs_enable), 32'(PRESENT));
    endtask : t_reset

    task automatic t_doze;
        for (int r = 1; r < 8; r++) begin
            bus(1'h1, ADDR_CLOCK_DIVISOR_REGISTER, rat(r));
            bus(1'h1, ADDR_CLOCK_DIVISOR_REGISTER, rat(r) | DZ_EN);
            ticks(256, 256 >> r);
            bus(1'h1, ADDR_CLOCK_DIVISOR_REGISTER, 32'h0);
        end
        bus(1'h1, ADDR_CLOCK_DIVISOR_REGISTER, rat(3) | DZ_EN);
        bus(1'h1, ADDR_CLOCK_DIVISOR_REGISTER, rat(5) | DZ_EN);
        rchk("ratio_lock", ADDR_CLOCK_DIVISOR_REGISTER, 32'hf800, rat(3) | DZ_EN);
        bus(1'h1, ADDR_CLOCK_DIVISOR_REGISTER, 32'h0);
        bus(1'h1, ADDR_CLOCK_DIVISOR_REGISTER, 32'h0);
        bus(1'h1, ADDR_CLOCK_DIVISOR_REGISTER, DZ_EN);
        rchk("en_zero", ADDR_CLOCK_DIVISOR_REGISTER, 32'hf800, 32'h0);
        ticks(64, 64);
        bus(1'h1, ADDR_CLOCK_DIVISOR_REGISTER, rat(7) | DZ_ROI | DZ_EN);
        irq(2);
        rchk("roi_clear", ADDR_CLOCK_DIVISOR_REGISTER, 32'hf800, rat(7) | DZ_ROI);
        ticks(64, 64);
        bus(1'h1, ADDR_CLOCK_DIVISOR_REGISTER, rat(1) | DZ_EN);
        irq(2);
        rchk("no_roi", ADDR_CLOCK_DIVISOR_REGISTER, 32'hf800, rat(1) | DZ_EN);
        ticks(64, 32);
        bus(1'h1, ADDR_CLOCK_DIVISOR_REGISTER, 32'h0);
    endtask : t_doze

    task automatic t_pmd;
        bus(1'h1, ADDR_PMD, 32'h4);
        @(posedge clock);
        chk("pmd_hold", 32'(module_clock_enable[2]), 32'h1);
        @(posedge clock);
        chk("pmd_clk", 32'(module_clock_enable), 32'(PRESENT & 16'hfffb));
        chk("pmd_regs", 32'(module_regs_enable), 32'(PRESENT & 16'hfffb));
        bus(1'h1, ADDR_PMD, 32'hffff);
        rchk("pmd_absent", ADDR_PMD, 32'hffff, 32'(PRESENT));
        bus(1'h1, ADDR_PMD, 32'h0);
        repeat (3) @(posedge clock);
        chk("pmd_back", 32'(module_clock_enable), 32'(PRESENT));
    endtask : t_pmd

    task automatic t_sleep;
        bus(1'h1, ADDR_RESET_CONTROL_REGISTER, 32'h1 << CORE_REGULATOR_KEEP_ACTIVE_BIT);
        watchdog_enabled <= 1'h1;
        clock_fail_monitor_enabled <= 1'h1;
        clock_source_select <= 3'h5;
        pwr(OP_SLEEP);
        @(posedge clock);
        chk("osc", 32'(system_clock_source_on), 32'h0);
        chk("cpu_clk", 32'(cpu_clock_enable), 32'h0);
        chk("cfm", 32'(clock_fail_monitor_active), 32'h0);
        chk("low_power_rc_clock", 32'(low_power_rc_clock_enable), 32'h1);
        chk("vreg", 32'({core_regulator_standby, flash_regulator_standby}), 32'h1);
        chk("periph", 32'(module_clock_enable), 32'(PRESENT & external_clocked));
        rchk("st_sleep", ADDR_STATUS, 32'hf, 32'h2);
        clock_source_select <= 3'h1;
        @(posedge clock);
        irq_req <= 1'h1;
        until_run(1'h1);
        irq_req <= 1'h0;
        chk("wake", 32'(n >= WAKE_MIN_CYCLES + 3 && n <= WAKE_MAX_CYCLES + 4), 32'h1);
        chk("restart_src", 32'(restart_clock_source), 32'h5);
    endtask : t_sleep

    task automatic t_idle;
        pwr(OP_IDLE);
        watchdog_enabled <= 1'h0;
        repeat (2) @(posedge clock);
        chk("osc_idle", 32'(system_clock_source_on), 32'h1);
        chk("cpu_idle", 32'(cpu_clock_enable), 32'h0);
        chk("low_power_rc_clock_idle", 32'(low_power_rc_clock_enable), 32'h1);
        chk("stop_idle", 32'(module_clock_enable), 32'(PRESENT & ~stop_in_idle));
        rchk("st_idle", ADDR_STATUS, 32'hf, 32'h4);
        @(posedge clock);
        watchdog_timeout <= 1'h1;
        until_run(1'h1);
        watchdog_timeout <= 1'h0;
        chk("wdt_wake", 32'(cpu_run), 32'h1);
    endtask : t_idle

    task automatic t_coincident;
        @(posedge clock);
        exec_req <= 1'h1;
        exec_op <= OP_SLEEP;
        irq_req <= 1'h1;
        @(posedge clock);
        exec_req <= 1'h0;
        until_run(1'h0);
        chk("entered", 32'(cpu_run), 32'h0);
        until_run(1'h1);
        irq_req <= 1'h0;
        chk("held_wake", 32'(cpu_run === 1'h1 && n <= WAKE_MAX_CYCLES + 3), 32'h1);
    endtask : t_coincident

    initial begin
        #4_000_000;
        n_errors++;
        test_done();
    end

    initial begin
        {arst_n, avs_read, avs_write, exec_req, exec_op, irq_req, watchdog_timeout} = 7'h0;
        {watchdog_enabled, clock_fail_monitor_enabled} = 2'h0;
        avs_address = 4'h0;
        avs_writedata = 32'h0;
        clock_source_select = 3'h2;
        stop_in_idle = 16'h00f0;
        external_clocked = 16'h8011;
        repeat (16) @(posedge clock);
        arst_n <= 1'h1;
        repeat (5) @(posedge clock);
        t_reset();
        t_doze();
        t_pmd();
        t_sleep();
        t_idle();
        t_coincident();
        test_done();
    end
endmodule : power_mode_clock_gating_bench
`default_nettype wire

// ==== common/pmcg_pkg.sv ====
// Package of constants for the power-mode and clock-gating controller
package pmcg_pkg;
    // Register byte addresses on the Avalon-MM slave
    localparam logic [3:0] ADDR_CLOCK_DIVISOR_REGISTER = 4'h0;
    localparam logic [3:0] ADDR_RESET_CONTROL_REGISTER = 4'h4;
    localparam logic [3:0] ADDR_PMD = 4'h8;
    localparam logic [3:0] ADDR_STATUS = 4'hc;
    // Clock divisor register fields
    localparam int ROI_BIT = 15;
    localparam int DOZE_LSB = 12;
    localparam int CPU_SLOWDOWN_ENABLE_BIT = 11;
    // Reset control register fields
    localparam int FLASH_REGULATOR_KEEP_ACTIVE_BIT = 11;
    localparam int CORE_REGULATOR_KEEP_ACTIVE_BIT = 8;
    // Reset values
    localparam logic [2:0] DOZE_RESET = 3'h0;
    localparam logic [31:0] UNMAPPED_READ = 32'h0000_0000;
    // Operand of the power-save instruction
    localparam logic OP_SLEEP = 1'b0;
    localparam logic OP_IDLE = 1'b1;
    // Wake restart delay, in clock cycles, within the two to four window
    localparam int WAKE_MIN_CYCLES = 2;
    localparam int WAKE_MAX_CYCLES = 4;
    localparam logic [2:0] WAKE_DELAY = 3'h3;
    // Module disable takes effect after one instruction cycle
    localparam int PMD_DELAY_CYCLES = 1;
    typedef enum logic [3:0] {
        PMCG_RUN = 4'b0001,
        PMCG_SLEEP = 4'b0010,
        PMCG_IDLE = 4'b0100,
        PMCG_WAKE = 4'b1000
    } pmcg_state_e;
endpackage : pmcg_pkg

// ==== hdl/pmcg_doze_div.sv ====
// CPU slowdown clock-enable generator
`timescale 1ns/1ps
`default_nettype none
module pmcg_doze_div (
    // Clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // Control
    input wire logic active,
    input wire logic [2:0] ratio,
    // Enable pulse
    output logic tick
);
    import pmcg_pkg::*;
    logic [6:0] count;
    logic [6:0] next_count;
    logic next_tick;

    function automatic logic [6:0] ratio_mask(input logic [2:0] r);
        ratio_mask = 7'((8'h01 << r) - 8'h01);
    endfunction : ratio_mask

    // Pulse once every 2**ratio cycles; every cycle when not slowed
    always_comb begin
        next_count = count + 7'h01; // RULE_26
        next_tick = 1'b0;
        if (!active || ratio == 3'h0) begin
            next_count = 7'h00;
            next_tick = 1'b1;
        end else if ((count & ratio_mask(ratio)) == ratio_mask(ratio)) begin
            next_count = 7'h00;
            next_tick = 1'b1; // RULE_26
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            count <= 7'h00;
            tick <= 1'b1;
        end else begin
            count <= next_count;
            tick <= next_tick;
        end
    end
endmodule : pmcg_doze_div
`default_nettype wire

// ==== hdl/pmcg_top.sv ====
// Power-mode controller with Sleep, Idle, Doze and module clock gating
// What this block does
// (RULE_01) The power-save instruction enters Sleep or Idle by its operand.
// (RULE_02) Sleep stops the system clock source and oscillator and halts execution.
// (RULE_03) Idle stops CPU clock only; system clock and peripherals without stop-in-idle keep running.
// (RULE_04) Enabled interrupt, watchdog time-out or any reset wakes the device.
// (RULE_05) The clock-fail monitor is off throughout Sleep.
// (RULE_06) Low-power RC clock runs in Sleep if the watchdog is enabled.
// (RULE_07) Enabled watchdog count is cleared just before Sleep entry.
// (RULE_08) Sleep disables every peripheral clocked from the system clock.
// (RULE_09) Wake from Sleep restarts on the clock source selected at entry.
// (RULE_10) Two bits keep core and flash regulators active in Sleep; default standby.
// (RULE_11) Idle entry clears the watchdog count.
// (RULE_12) In Idle the RC clock runs if watchdog or clock-fail monitor enabled.
// (RULE_13) Wake from Idle resumes the CPU two to four cycles later.
// (RULE_14) A peripheral's stop-in-idle bit stops it during Idle.
// (RULE_15) An interrupt during the instruction is held, then wakes at once.
// (RULE_16) Doze slows only the CPU; system and peripheral clocks are unchanged.
// (RULE_17) Setting the slowdown enable bit activates Doze.
// (RULE_18) Three-bit ratio selects 1:1 to 1:128; reset default 1:1.
// (RULE_19) Restore-on-interrupt makes interrupts return the CPU to full speed.
// (RULE_20) A set module disable bit stops all of that module's clocks.
// (RULE_21) A module runs only if present and not disabled; resets enabled.
// (RULE_22) Disable bit changes take effect after exactly one instruction cycle.
// (RULE_23) Ratio writes are ignored while slowdown enable is set.
// (RULE_24) Setting slowdown enable is ignored while the ratio is zero.
// (RULE_25) Restore-on-interrupt with an interrupt clears slowdown enable in hardware.
// (RULE_26) Slowed CPU clock is an enable once every 2**ratio cycles.
//
// The register addresses and the Avalon-MM slave port are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module pmcg_top #(
    parameter int NUM_MODULES = 16,
    parameter logic [NUM_MODULES-1:0] MODULE_PRESENT = '1
) (
    // Clock and reset
    input wire logic clock,
    input wire logic arst_n,
    // Avalon-MM slave
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // CPU core
    input wire logic power_save_instruction,
    input wire logic power_save_operand,
    input wire logic irq_pending,
    output logic cpu_clock_enable,
    output logic cpu_run,
    // Watchdog and clock monitor
    input wire logic watchdog_enabled,
    input wire logic clock_fail_monitor_enabled,
    input wire logic watchdog_timeout,
    output logic watchdog_clear,
    output logic low_power_rc_clock_enable,
    output logic clock_fail_monitor_active,
    // Oscillator
    input wire logic [2:0] clock_source_select,
    output logic system_clock_source_on,
    output logic [2:0] restart_clock_source,
    // Regulators
    output logic core_regulator_standby,
    output logic flash_regulator_standby,
    // Peripherals
    input wire logic [NUM_MODULES-1:0] stop_in_idle,
    input wire logic [NUM_MODULES-1:0] external_clocked,
    output logic [NUM_MODULES-1:0] module_clock_enable,
    output logic [NUM_MODULES-1:0] module_regs_enable
);
    import pmcg_pkg::*;

    initial begin
        if (NUM_MODULES < 1 || NUM_MODULES > 32) begin
            $error("NUM_MODULES must be 1 to 32");
        end
    end

    // Reset release synchroniser
    logic rst_meta;
    logic rst_n;
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            rst_meta <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n <= rst_meta;
        end
    end

    // Asynchronous pins
    logic wdt_to_meta;
    logic wdt_to;
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            wdt_to_meta <= 1'b0;
            wdt_to <= 1'b0;
        end else begin
            wdt_to_meta <= watchdog_timeout;
            wdt_to <= wdt_to_meta;
        end
    end

    // Register state
    logic restore_on_interrupt;
    logic cpu_slowdown_enable;
    logic [2:0] doze_ratio;
    logic core_regulator_keep_active;
    logic flash_regulator_keep_active;
    logic [NUM_MODULES-1:0] module_clock_disable_bit;
    logic [NUM_MODULES-1:0] pmd_eff;
    logic next_roi;
    logic next_cpu_slowdown_enable;
    logic [2:0] next_doze_ratio;
    logic next_core_regulator_keep_active;
    logic next_flash_regulator_keep_active;
    logic [NUM_MODULES-1:0] next_pmd;
    logic [31:0] next_readdata;
    logic next_waitrequest;

    // Power state
    pmcg_state_e state;
    pmcg_state_e next_state;
    logic [2:0] wake_cnt;
    logic [2:0] next_wake_cnt;
    logic [2:0] entry_src;
    logic [2:0] next_entry_src;
    logic next_wdt_clear;

    logic access;
    logic doze_tick;
    assign access = (avs_read || avs_write) && avs_waitrequest;

    // Registers: one wait state, then answer
    always_comb begin
        next_roi = restore_on_interrupt;
        next_cpu_slowdown_enable = cpu_slowdown_enable;
        next_doze_ratio = doze_ratio;
        next_core_regulator_keep_active = core_regulator_keep_active;
        next_flash_regulator_keep_active = flash_regulator_keep_active;
        next_pmd = module_clock_disable_bit;
        next_readdata = avs_readdata;
        next_waitrequest = 1'b1;
        if (access && avs_write) begin
            next_waitrequest = 1'b0;
            if (avs_address == ADDR_CLOCK_DIVISOR_REGISTER) begin
                next_roi = avs_writedata[ROI_BIT];
                if (!cpu_slowdown_enable) begin
                    next_doze_ratio = avs_writedata[DOZE_LSB +: 3]; // RULE_23
                end
                if (avs_writedata[CPU_SLOWDOWN_ENABLE_BIT] && next_doze_ratio == 3'h0) begin
                    next_cpu_slowdown_enable = 1'b0; // RULE_24
                end else begin
                    next_cpu_slowdown_enable = avs_writedata[CPU_SLOWDOWN_ENABLE_BIT]; // RULE_17
                end
            end else if (avs_address == ADDR_RESET_CONTROL_REGISTER) begin
                next_core_regulator_keep_active = avs_writedata[CORE_REGULATOR_KEEP_ACTIVE_BIT]; // RULE_10
                next_flash_regulator_keep_active = avs_writedata[FLASH_REGULATOR_KEEP_ACTIVE_BIT];
            end else if (avs_address == ADDR_PMD) begin
                next_pmd = avs_writedata[NUM_MODULES-1:0] & MODULE_PRESENT;
            end
        end else if (access && avs_read) begin
            next_waitrequest = 1'b0;
            next_readdata = UNMAPPED_READ;
            if (avs_address == ADDR_CLOCK_DIVISOR_REGISTER) begin
                next_readdata[ROI_BIT] = restore_on_interrupt;
                next_readdata[DOZE_LSB +: 3] = doze_ratio;
                next_readdata[CPU_SLOWDOWN_ENABLE_BIT] = cpu_slowdown_enable;
            end else if (avs_address == ADDR_RESET_CONTROL_REGISTER) begin
                next_readdata[CORE_REGULATOR_KEEP_ACTIVE_BIT] = core_regulator_keep_active;
                next_readdata[FLASH_REGULATOR_KEEP_ACTIVE_BIT] = flash_regulator_keep_active;
            end else if (avs_address == ADDR_PMD) begin
                next_readdata[NUM_MODULES-1:0] = module_clock_disable_bit;
            end else if (avs_address == ADDR_STATUS) begin
                next_readdata[3:0] = state;
                next_readdata[4] = doze_tick;
            end
        end
        // Hardware clear wins over a software set in the same cycle
        if (restore_on_interrupt && irq_pending) begin
            next_cpu_slowdown_enable = 1'b0; // RULE_25 RULE_19
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            restore_on_interrupt <= 1'b0;
            cpu_slowdown_enable <= 1'b0;
            doze_ratio <= DOZE_RESET; // RULE_18
            core_regulator_keep_active <= 1'b0;
            flash_regulator_keep_active <= 1'b0;
            module_clock_disable_bit <= '0; // RULE_21
            pmd_eff <= '0;
            avs_readdata <= UNMAPPED_READ;
            avs_waitrequest <= 1'b1;
        end else begin
            restore_on_interrupt <= next_roi;
            cpu_slowdown_enable <= next_cpu_slowdown_enable;
            doze_ratio <= next_doze_ratio;
            core_regulator_keep_active <= next_core_regulator_keep_active;
            flash_regulator_keep_active <= next_flash_regulator_keep_active;
            module_clock_disable_bit <= next_pmd;
            pmd_eff <= module_clock_disable_bit; // RULE_22
            avs_readdata <= next_readdata;
            avs_waitrequest <= next_waitrequest;
        end
    end

    pmcg_doze_div u_doze (
        .clock(clock),
        .rst_n(rst_n),
        .active(cpu_slowdown_enable), // RULE_16
        .ratio(doze_ratio),
        .tick(doze_tick)
    );

    // Power state machine
    logic wake_event;
    assign wake_event = irq_pending || wdt_to; // RULE_04 RULE_15

    always_comb begin
        next_state = state;
        next_wake_cnt = wake_cnt;
        next_entry_src = entry_src;
        next_wdt_clear = 1'b0;
        case (state)
            PMCG_RUN: begin
                next_entry_src = clock_source_select;
                if (power_save_instruction) begin
                    next_wdt_clear = watchdog_enabled; // RULE_07 RULE_11
                    next_state = (power_save_operand == OP_SLEEP) ? PMCG_SLEEP : PMCG_IDLE; // RULE_01
                end
            end
            PMCG_SLEEP, PMCG_IDLE: begin
                if (wake_event) begin
                    next_state = PMCG_WAKE;
                    next_wake_cnt = WAKE_DELAY - 3'h1;
                end
            end
            PMCG_WAKE: begin
                next_wake_cnt = wake_cnt - 3'h1;
                if (wake_cnt == 3'h0) begin
                    next_state = PMCG_RUN; // RULE_13
                end
            end
            default: begin
                next_state = PMCG_RUN;
            end
        endcase
    end

    // Output decode from next state, so every output is a flip-flop
    logic in_sleep;
    logic in_idle;
    assign in_sleep = next_state == PMCG_SLEEP;
    assign in_idle = next_state == PMCG_IDLE;

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            state <= PMCG_RUN;
            wake_cnt <= 3'h0;
            entry_src <= 3'h0;
            watchdog_clear <= 1'b0;
            cpu_run <= 1'b1;
            cpu_clock_enable <= 1'b1;
            system_clock_source_on <= 1'b1;
            clock_fail_monitor_active <= 1'b0;
            low_power_rc_clock_enable <= 1'b0;
            restart_clock_source <= 3'h0;
            core_regulator_standby <= 1'b0;
            flash_regulator_standby <= 1'b0;
            module_clock_enable <= '0;
            module_regs_enable <= '0;
        end else begin
            state <= next_state;
            wake_cnt <= next_wake_cnt;
            entry_src <= next_entry_src;
            watchdog_clear <= next_wdt_clear;
            cpu_run <= next_state == PMCG_RUN; // RULE_03
            cpu_clock_enable <= (next_state == PMCG_RUN) && doze_tick;
            system_clock_source_on <= !in_sleep; // RULE_02
            clock_fail_monitor_active <= clock_fail_monitor_enabled && !in_sleep; // RULE_05
            low_power_rc_clock_enable <= in_sleep ? watchdog_enabled // RULE_06
                : (watchdog_enabled || clock_fail_monitor_enabled); // RULE_12
            restart_clock_source <= next_entry_src; // RULE_09
            core_regulator_standby <= in_sleep && !core_regulator_keep_active; // RULE_10
            flash_regulator_standby <= in_sleep && !flash_regulator_keep_active;
            module_clock_enable <= MODULE_PRESENT & ~pmd_eff // RULE_20 RULE_21
                & ~({NUM_MODULES{in_idle}} & stop_in_idle) // RULE_14
                & ({NUM_MODULES{!in_sleep}} | external_clocked); // RULE_08
            module_regs_enable <= MODULE_PRESENT & ~pmd_eff; // RULE_20
        end
    end

    // Checks
    AST_SLEEP_ENTRY: assert property (@(posedge clock) disable iff (!rst_n) // RULE_01
        state == PMCG_RUN && power_save_instruction && power_save_operand == OP_SLEEP |=> state == PMCG_SLEEP)
        else $error("sleep not entered");
    AST_IDLE_ENTRY: assert property (@(posedge clock) disable iff (!rst_n) // RULE_01
        state == PMCG_RUN && power_save_instruction && power_save_operand == OP_IDLE |=> state == PMCG_IDLE)
        else $error("idle not entered");
    AST_SLEEP_CLOCK_OFF: assert property (@(posedge clock) disable iff (!rst_n) // RULE_02
        state == PMCG_SLEEP |-> !system_clock_source_on && !cpu_run)
        else $error("clock source on in sleep");
    AST_IDLE_CLOCK_ON: assert property (@(posedge clock) disable iff (!rst_n) // RULE_03
        state == PMCG_IDLE |-> system_clock_source_on && !cpu_clock_enable)
        else $error("idle clocks wrong");
    AST_WAKE: assert property (@(posedge clock) disable iff (!rst_n) // RULE_04
        (state == PMCG_SLEEP || state == PMCG_IDLE) && wake_event |=> state == PMCG_WAKE ##[2:4] cpu_run)
        else $error("wake not within bound");
    AST_CLOCK_FAIL_MONITOR_OFF: assert property (@(posedge clock) disable iff (!rst_n) // RULE_05
        state == PMCG_SLEEP |-> !clock_fail_monitor_active)
        else $error("monitor active in sleep");
    AST_WDT_CLEAR: assert property (@(posedge clock) disable iff (!rst_n) // RULE_07
        state == PMCG_RUN && power_save_instruction && watchdog_enabled |=> watchdog_clear)
        else $error("watchdog not cleared");
    AST_RATIO_LOCK: assert property (@(posedge clock) disable iff (!rst_n) // RULE_23
        cpu_slowdown_enable |=> $stable(doze_ratio))
        else $error("ratio changed while dozing");
    AST_CPU_SLOWDOWN_ENABLE_ZERO: assert property (@(posedge clock) disable iff (!rst_n) // RULE_24
        doze_ratio == 3'h0 && !cpu_slowdown_enable |=> !cpu_slowdown_enable || doze_ratio != 3'h0)
        else $error("doze set with zero ratio");
    AST_ROI_CLEAR: assert property (@(posedge clock) disable iff (!rst_n) // RULE_25
        restore_on_interrupt && irq_pending |=> !cpu_slowdown_enable)
        else $error("doze not cleared by interrupt");
    AST_PMD_DELAY: assert property (@(posedge clock) disable iff (!rst_n) // RULE_22
        $changed(module_clock_disable_bit) |=> pmd_eff == $past(module_clock_disable_bit) ##1 module_regs_enable == (MODULE_PRESENT & ~$past(module_clock_disable_bit, 2)))
        else $error("module disable delay wrong");
endmodule : pmcg_top
`default_nettype wire
